// ---- src/timer_pkg.sv ----
// Shared constants and types of the multi-mode process timer
package timer_pkg;

	// Timer behaviour selected by the type field
	typedef enum logic [2:0] {
		TYPE_OFF     = 3'h0,
		PULSE_MODE   = 3'h1,
		DELAY_MODE   = 3'h2,
		ONESHOT_MODE = 3'h3,
		MINON_MODE   = 3'h4
	} timer_type_e;

	// Duration in minutes and seconds
	typedef struct packed {
		logic [9:0] mins;
		logic [5:0] secs;
	} mmss_s;

	localparam logic [9:0] MINS_MAX   = 10'h3E7;
	localparam logic [5:0] SECS_MAX   = 6'h3B;
	localparam mmss_s      MMSS_ZERO  = '{mins: 10'h000, secs: 6'h00};
	localparam mmss_s      MMSS_ONE   = '{mins: 10'h000, secs: 6'h01};
	localparam mmss_s      MMSS_MAX   = '{mins: MINS_MAX, secs: SECS_MAX};
	localparam timer_type_e TYPE_RST  = TYPE_OFF;

	// Tick of one second from the 200 MHz system clock
	localparam int unsigned CLK_PERIOD_PS  = 5000;
	localparam int unsigned TICK_PERIOD_US = 1000000;
	localparam int unsigned TICK_CYCLES_DEF = ((TICK_PERIOD_US * 1000) / CLK_PERIOD_PS) * 1000;

endpackage : timer_pkg

// ---- src/tick_prescaler.sv ----
// Divider that turns the system clock into a one-cycle timing tick
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler #(
	parameter int unsigned CYCLES = 200000000
) (
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_restart,
	output logic      o_tick
);
	localparam int unsigned     CW   = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0]   LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic          tick_reg;
	logic          tick_next;

	// Restart realigns the second so a fresh period lasts a full tick
	always_comb begin
		cnt_next  = cnt_reg + CW'(1);
		tick_next = 1'b0;
		if (i_restart) begin
			cnt_next = '0;
		end else if (cnt_reg == LAST) begin
			cnt_next  = '0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign o_tick = tick_reg;

	property p_tick_gap;
		@(posedge i_clk) disable iff (!i_nrst) o_tick |=> !o_tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("tick lasted two cycles");

	property p_tick_after_restart;
		@(posedge i_clk) disable iff (!i_nrst) i_restart |=> !o_tick;
	endproperty
	a_tick_after_restart: assert property (p_tick_after_restart) else $error("tick right after restart");

endmodule : tick_prescaler
`default_nettype wire

// ---- src/multi_mode_process_timer.sv ----
// Multi-mode process timer: on-pulse, on-delay, one-shot and minimum-on
//
// Overview of operation
// - Type field selects off, pulse, delay, one-shot, minimum-on
// - Set duration zero to 999:59, default zero
// - Pulse and delay copy duration at start; one-shot decrements it
// - Read-only elapsed time, same range
// - Input inactive by default; one starts timing
// - Triggered flag shows timer running
// - Pulse: output on at trigger until elapsed
// - Pulse: new trigger restarts the period
// - Delay: output on after input held duration
// - Delay: early input drop keeps output off
// - One-shot: decrement per tick, zero clears output
// - One-shot: duration may be rewritten any time
// - One-shot: zero stays; operator rewrites duration
// - One-shot: gate low holds count, output off
// - One-shot: flag set on nonzero write, cleared at end or on zero write
// - Minimum-on: input rise turns output on
// - Minimum-on: input fall starts elapsed counting
// - Minimum-on: output off when elapsed reaches duration
// - Minimum-on: input return clears elapsed, waits
// - Minimum-on: flag set while elapsed above zero
`timescale 1ns/1ps
`default_nettype none
module multi_mode_process_timer import timer_pkg::*; #(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
	input  wire logic       I_CLK,
	input  wire logic       I_NRST,
	input  wire logic [2:0] I_TYPE,
	input  wire logic       I_TIME_WR,
	input  wire mmss_s      I_TIME,
	input  wire logic       I_IN,
	output logic            O_OUT,
	output logic            O_TIMING_ACTIVE_FLAG,
	output mmss_s           O_TIME,
	output mmss_s           O_REMAIN,
	output mmss_s           O_ELAPSED
);

	logic        in_meta_reg;
	logic        in_sync_reg;
	logic        in_prev_reg;
	timer_type_e type_prev_reg;
	mmss_s       set_reg;
	mmss_s       set_next;
	mmss_s       remain_reg;
	mmss_s       remain_next;
	mmss_s       elapsed_reg;
	mmss_s       elapsed_next;
	logic        out_reg;
	logic        out_next;
	logic        trig_reg;
	logic        trig_next;
	logic        count_reg;
	logic        count_next;
	timer_type_e mode;
	logic        mode_chg;
	logic        rise;
	logic        fall;
	logic        restart;
	logic        tick;
	mmss_s       wr_val;

	function automatic mmss_s mmss_inc(input mmss_s v);
		mmss_s r;
		r = v;
		if (v == MMSS_MAX) begin
			r = MMSS_MAX;
		end else if (v.secs >= SECS_MAX) begin
			r.secs = 6'h00;
			r.mins = v.mins + 10'h001;
		end else begin
			r.secs = v.secs + 6'h01;
		end
		return r;
	endfunction : mmss_inc

	function automatic mmss_s mmss_dec(input mmss_s v);
		mmss_s r;
		r = v;
		if (v == MMSS_ZERO) begin
			r = MMSS_ZERO;
		end else if (v.secs == 6'h00) begin
			r.secs = SECS_MAX;
			r.mins = v.mins - 10'h001;
		end else begin
			r.secs = v.secs - 6'h01;
		end
		return r;
	endfunction : mmss_dec

	// Out-of-range entries saturate rather than wrap
	function automatic mmss_s mmss_clamp(input mmss_s v);
		mmss_s r;
		r = v;
		if (v.mins > MINS_MAX) begin
			r.mins = MINS_MAX;
		end
		if (v.secs > SECS_MAX) begin
			r.secs = SECS_MAX;
		end
		return r;
	endfunction : mmss_clamp

	tick_prescaler #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.i_clk     (I_CLK),
		.i_nrst    (I_NRST),
		.i_restart (restart),
		.o_tick    (tick)
	);

	// Codes 5 to 7 behave as off
	always_comb begin
		case (I_TYPE)
			3'h1:    mode = PULSE_MODE;
			3'h2:    mode = DELAY_MODE;
			3'h3:    mode = ONESHOT_MODE;
			3'h4:    mode = MINON_MODE;
			default: mode = TYPE_OFF;
		endcase
	end

	assign mode_chg = (mode != type_prev_reg);
	assign rise     = in_sync_reg && !in_prev_reg;
	assign fall     = !in_sync_reg && in_prev_reg;
	assign wr_val   = mmss_clamp(I_TIME);

	always_comb begin
		set_next     = I_TIME_WR ? wr_val : set_reg;
		remain_next  = remain_reg;
		elapsed_next = elapsed_reg;
		out_next     = out_reg;
		trig_next    = trig_reg;
		count_next   = count_reg;
		restart      = mode_chg;
		if (mode_chg || mode == TYPE_OFF) begin
			out_next     = 1'b0;
			trig_next    = 1'b0;
			elapsed_next = MMSS_ZERO;
			remain_next  = MMSS_ZERO;
			count_next   = 1'b0;
		end else begin
			case (mode)
				PULSE_MODE: begin
					if (rise) begin
						remain_next  = set_reg;
						elapsed_next = MMSS_ZERO;
						out_next     = (set_reg != MMSS_ZERO);
						trig_next    = out_next;
						restart      = 1'b1;
					end else if (out_reg && tick) begin
						remain_next  = mmss_dec(remain_reg);
						elapsed_next = mmss_inc(elapsed_reg);
						if (remain_next == MMSS_ZERO) begin
							out_next  = 1'b0;
							trig_next = 1'b0;
						end
					end
				end
				DELAY_MODE: begin
					if (!in_sync_reg) begin
						out_next     = 1'b0;
						trig_next    = 1'b0;
						remain_next  = MMSS_ZERO;
						elapsed_next = MMSS_ZERO;
					end else if (rise) begin
						remain_next  = set_reg;
						elapsed_next = MMSS_ZERO;
						trig_next    = 1'b1;
						out_next     = (set_reg == MMSS_ZERO);
						restart      = 1'b1;
					end else if (trig_reg && !out_reg && tick) begin
						remain_next  = mmss_dec(remain_reg);
						elapsed_next = mmss_inc(elapsed_reg);
						if (remain_next == MMSS_ZERO) begin
							out_next = 1'b1;
						end
					end
				end
				ONESHOT_MODE: begin
					// A write replaces the running value and is never undone
					if (I_TIME_WR) begin
						trig_next = (wr_val != MMSS_ZERO);
						restart   = 1'b1;
					end else if (trig_reg && in_sync_reg && tick) begin
						set_next     = mmss_dec(set_reg);
						elapsed_next = mmss_inc(elapsed_reg);
						if (set_next == MMSS_ZERO) begin
							trig_next = 1'b0;
						end
					end
					out_next    = trig_next && in_sync_reg && (set_next != MMSS_ZERO);
					remain_next = set_next;
				end
				MINON_MODE: begin
					if (rise) begin
						out_next     = 1'b1;
						elapsed_next = MMSS_ZERO;
						count_next   = 1'b0;
					end else if (fall && out_reg) begin
						if (set_reg == MMSS_ZERO) begin
							out_next = 1'b0;
						end else begin
							count_next = 1'b1;
							restart    = 1'b1;
						end
					end else if (count_reg && tick) begin
						elapsed_next = mmss_inc(elapsed_reg);
						// Compare as packed value; a shortened duration ends at the next tick
						if (elapsed_next >= set_reg) begin
							out_next     = 1'b0;
							count_next   = 1'b0;
							elapsed_next = MMSS_ZERO;
						end
					end
					trig_next   = (elapsed_next != MMSS_ZERO);
					remain_next = set_reg;
				end
				default: begin
					out_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			in_meta_reg   <= 1'b0;
			in_sync_reg   <= 1'b0;
			in_prev_reg   <= 1'b0;
			type_prev_reg <= TYPE_RST;
			set_reg       <= MMSS_ZERO;
			remain_reg    <= MMSS_ZERO;
			elapsed_reg   <= MMSS_ZERO;
			out_reg       <= 1'b0;
			trig_reg      <= 1'b0;
			count_reg     <= 1'b0;
		end else begin
			in_meta_reg   <= I_IN;
			in_sync_reg   <= in_meta_reg;
			in_prev_reg   <= in_sync_reg;
			type_prev_reg <= mode;
			set_reg       <= set_next;
			remain_reg    <= remain_next;
			elapsed_reg   <= elapsed_next;
			out_reg       <= out_next;
			trig_reg      <= trig_next;
			count_reg     <= count_next;
		end
	end

	assign O_OUT                = out_reg;
	assign O_TIMING_ACTIVE_FLAG = trig_reg;
	assign O_TIME               = set_reg;
	assign O_REMAIN             = remain_reg;
	assign O_ELAPSED            = elapsed_reg;

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_NRST);

	sequence s_pulse_rise;
		mode == PULSE_MODE && !mode_chg && rise;
	endsequence

	sequence s_minon_rise;
		mode == MINON_MODE && !mode_chg && rise;
	endsequence

	sequence s_minon_fall;
		mode == MINON_MODE && !mode_chg && !rise && fall && out_reg;
	endsequence

	property p_off_clears;
		(mode == TYPE_OFF || mode_chg) |=> !out_reg && !trig_reg && elapsed_reg == MMSS_ZERO;
	endproperty
	a_off_clears: assert property (p_off_clears) else $error("off or type change left timer active");

	property p_bad_type;
		(I_TYPE > 3'h4) |=> !out_reg ##1 !out_reg;
	endproperty
	a_bad_type: assert property (p_bad_type) else $error("undefined type drove output");

	property p_ranges;
		set_reg.mins <= MINS_MAX && set_reg.secs <= SECS_MAX && elapsed_reg.secs <= SECS_MAX;
	endproperty
	a_ranges: assert property (p_ranges) else $error("duration out of range");

	property p_pulse_start;
		s_pulse_rise |=> remain_reg == $past(set_reg) && out_reg == ($past(set_reg) != MMSS_ZERO);
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("pulse start did not load duration");

	property p_pulse_last;
		mode == PULSE_MODE && !mode_chg && !rise && out_reg && tick && remain_reg == MMSS_ONE |=> !out_reg;
	endproperty
	a_pulse_last: assert property (p_pulse_last) else $error("pulse outlived its duration");

	property p_delay_gate;
		mode == DELAY_MODE && !in_sync_reg |=> !out_reg && !trig_reg;
	endproperty
	a_delay_gate: assert property (p_delay_gate) else $error("delay output on with input off");

	property p_delay_on;
		$rose(out_reg) && type_prev_reg == DELAY_MODE |-> $past(in_sync_reg);
	endproperty
	a_delay_on: assert property (p_delay_on) else $error("delay output rose without input");

	property p_oneshot_hold;
		mode == ONESHOT_MODE && !mode_chg && !in_sync_reg && !I_TIME_WR |=> !out_reg && set_reg == $past(set_reg);
	endproperty
	a_oneshot_hold: assert property (p_oneshot_hold) else $error("one-shot ran with gate off");

	property p_oneshot_write;
		mode == ONESHOT_MODE && !mode_chg && I_TIME_WR && wr_val != MMSS_ZERO |=> trig_reg && set_reg == $past(wr_val);
	endproperty
	a_oneshot_write: assert property (p_oneshot_write) else $error("one-shot write did not trigger");

	property p_oneshot_zero;
		type_prev_reg == ONESHOT_MODE && set_reg == MMSS_ZERO |-> !out_reg && !trig_reg;
	endproperty
	a_oneshot_zero: assert property (p_oneshot_zero) else $error("one-shot active at zero");

	property p_minon_rise;
		s_minon_rise |=> out_reg && elapsed_reg == MMSS_ZERO && !count_reg;
	endproperty
	a_minon_rise: assert property (p_minon_rise) else $error("minimum-on rise mishandled");

	property p_minon_fall;
		s_minon_fall |=> count_reg == ($past(set_reg) != MMSS_ZERO) && out_reg == count_reg;
	endproperty
	a_minon_fall: assert property (p_minon_fall) else $error("minimum-on fall mishandled");

	property p_minon_trig;
		type_prev_reg == MINON_MODE |-> trig_reg == (elapsed_reg != MMSS_ZERO);
	endproperty
	a_minon_trig: assert property (p_minon_trig) else $error("minimum-on flag disagrees with elapsed");

endmodule : multi_mode_process_timer
`default_nettype wire

// ---- tb/wired_input_source.sv ----
// Model of the wired digital source feeding the timer input
`timescale 1ns/1ps
`default_nettype none
module wired_input_source (
	output logic o_level
);
	// Unwired input reads off until driven
	initial o_level = 1'b0;
	// Caller sits at a falling edge, clear of the sampling edge
	task automatic set_level(input logic v);
		o_level = v;
	endtask : set_level
endmodule : wired_input_source
`default_nettype wire

// ---- tb/multi_mode_process_timer_tb.sv ----
// Self-checking bench of the multi-mode process timer
`timescale 1ns/1ps
`default_nettype none
module multi_mode_process_timer_tb import timer_pkg::*; ;
	// Short tick keeps the run brief; all timing derives from it
	localparam int    T  = 8;
	localparam mmss_s S2 = '{mins: 10'h000, secs: 6'h02};
	localparam mmss_s S3 = '{mins: 10'h000, secs: 6'h03};
	logic       clk      = 1'b0;
	logic       nrst     = 1'b0;
	logic [2:0] type_sel = 3'h0;
	logic       wr       = 1'b0;
	mmss_s      time_val = MMSS_ZERO;
	logic       in_lvl;
	logic       out_b;
	logic       flag;
	mmss_s      set_t;
	mmss_s      remain;
	mmss_s      elapsed;
	logic [2:0] offs [4] = '{3'h0, 3'h5, 3'h6, 3'h7};
	int         fails      = 0;
	int         num_checks = 0;

	always #2.5 clk = ~clk;

	wired_input_source wired_input_source_inst (.o_level(in_lvl));

	multi_mode_process_timer #(.TICK_CYCLES(T)) multi_mode_process_timer_inst (
		.I_CLK               (clk),
		.I_NRST              (nrst),
		.I_TYPE              (type_sel),
		.I_TIME_WR           (wr),
		.I_TIME              (time_val),
		.I_IN                (in_lvl),
		.O_OUT               (out_b),
		.O_TIMING_ACTIVE_FLAG(flag),
		.O_TIME              (set_t),
		.O_REMAIN            (remain),
		.O_ELAPSED           (elapsed)
	);

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	task automatic drive_in(input logic v);
		wired_input_source_inst.set_level(v);
	endtask : drive_in

	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			$display("Error at %0t: bit got %b exp %b", $time, got, exp);
			fails++;
		end
	endtask : chk_bit

	task automatic chk_time(input mmss_s got, input mmss_s exp);
		num_checks++;
		if (got !== exp) begin
			$display("Error at %0t: time got %h exp %h", $time, got, exp);
			fails++;
		end
	endtask : chk_time

	task automatic write_time(input mmss_s v);
		wr = 1'b1;
		time_val = v;
		tick(1);
		wr = 1'b0;
	endtask : write_time

	task automatic wait_out(input logic v, input int bound);
		int n;
		n = 0;
		while (out_b !== v && n < bound) begin
			tick(1);
			n++;
		end
		if (out_b !== v) begin
			$display("Error at %0t: output wait timed out", $time);
			fails++;
			give_verdict();
		end
	endtask : wait_out

	task automatic end_test(input string name);
		$display("Test %s finished", name);
	endtask : end_test

	task automatic pulse_start();
		chk_bit(out_b, 1'b1);
		chk_bit(flag, 1'b1);
		chk_time(remain, S2);
		chk_time(elapsed, MMSS_ZERO);
	endtask : pulse_start

	task automatic pulse_mid();
		chk_bit(out_b, 1'b1);
		chk_time(remain, MMSS_ONE);
		chk_time(elapsed, MMSS_ONE);
	endtask : pulse_mid

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	initial begin
		tick(8);
		nrst = 1'b1;
		tick(2);
		chk_bit(out_b, 1'b0);
		chk_bit(flag, 1'b0);
		chk_time(set_t, MMSS_ZERO);
		chk_time(elapsed, MMSS_ZERO);
		write_time('{mins: 10'h3FF, secs: 6'h3F});
		chk_time(set_t, MMSS_MAX);
		write_time(S2);
		end_test("reset");
		type_sel = PULSE_MODE;
		tick(2);
		drive_in(1'b1);
		tick(3);
		pulse_start();
		// Registered tick reaches the counters one cycle after the period
		tick(T + 1);
		pulse_mid();
		// Retrigger in the last second, before the period ends
		drive_in(1'b0);
		tick(2);
		drive_in(1'b1);
		tick(3);
		pulse_start();
		tick(T + 1);
		pulse_mid();
		tick(T);
		chk_bit(out_b, 1'b0);
		chk_bit(flag, 1'b0);
		chk_time(elapsed, S2);
		end_test("pulse");
		drive_in(1'b0);
		type_sel = DELAY_MODE;
		tick(3);
		drive_in(1'b1);
		tick(3 + T);
		chk_bit(flag, 1'b1);
		drive_in(1'b0);
		tick(4);
		chk_bit(out_b, 1'b0);
		drive_in(1'b1);
		tick(3 + 2 * T - 1);
		chk_bit(out_b, 1'b0);
		wait_out(1'b1, 4);
		tick(2 * T);
		chk_bit(out_b, 1'b1);
		drive_in(1'b0);
		wait_out(1'b0, 5);
		end_test("delay");
		type_sel = ONESHOT_MODE;
		drive_in(1'b1);
		tick(4);
		write_time(S2);
		chk_bit(flag, 1'b1);
		chk_bit(out_b, 1'b1);
		tick(T + 1);
		chk_time(set_t, MMSS_ONE);
		chk_time(elapsed, MMSS_ONE);
		drive_in(1'b0);
		tick(3 + T);
		chk_bit(out_b, 1'b0);
		chk_bit(flag, 1'b1);
		chk_time(set_t, MMSS_ONE);
		drive_in(1'b1);
		tick(3);
		write_time(S3);
		chk_time(set_t, S3);
		wait_out(1'b0, 3 * T + 6);
		chk_time(set_t, MMSS_ZERO);
		chk_bit(flag, 1'b0);
		tick(2 * T);
		chk_time(set_t, MMSS_ZERO);
		end_test("oneshot");
		drive_in(1'b0);
		type_sel = MINON_MODE;
		tick(3);
		write_time(S2);
		drive_in(1'b1);
		wait_out(1'b1, 5);
		tick(T);
		chk_time(elapsed, MMSS_ZERO);
		chk_bit(flag, 1'b0);
		drive_in(1'b0);
		tick(T + 4);
		chk_time(elapsed, MMSS_ONE);
		chk_bit(flag, 1'b1);
		drive_in(1'b1);
		tick(4);
		chk_time(elapsed, MMSS_ZERO);
		chk_bit(out_b, 1'b1);
		drive_in(1'b0);
		tick(T + 4);
		chk_bit(out_b, 1'b1);
		wait_out(1'b0, T + 4);
		chk_bit(flag, 1'b0);
		end_test("minon");
		for (int i = 0; i < 4; i++) begin
			type_sel = PULSE_MODE;
			drive_in(1'b0);
			tick(3);
			drive_in(1'b1);
			tick(3 + T);
			chk_bit(out_b, 1'b1);
			type_sel = offs[i];
			tick(2);
			chk_bit(out_b, 1'b0);
			chk_bit(flag, 1'b0);
			chk_time(elapsed, MMSS_ZERO);
			drive_in(1'b0);
			tick(3);
			drive_in(1'b1);
			tick(T + 3);
			chk_bit(out_b, 1'b0);
		end
		end_test("types");
		give_verdict();
	end
endmodule : multi_mode_process_timer_tb
`default_nettype wire
